// [logic/haa_aggregator.sv]
// Purpose: fault summaries, masked alert groups and health summary word
// Assumes: one clock, synchronous active-low reset, inputs synchronous
// Notes:   masks are reached only through the parameter read/write port
//
// Contract
// - algorithm fault summary is the OR of implemented algorithm fault bits.
// - algorithm word: bit0 start error, bit1 range fatal, bit2 deadline miss.
// - data fault summary is the OR of implemented data fault bits.
// - data bit0 set on bad calibration checksum or store write-unlock compromise.
// - magnetic alignment flag absent; data bits 1..15 never asserted.
// - hardware alert flag is OR of hardware word AND hardware mask.
// - hardware word bits 0..3: pps, receiver, correction, store unlocked.
// - link alert flag is OR of link word AND link mask.
// - link bit0 set while external navigation data is absent.
// - software alert flag is OR of software word AND software mask.
// - software word bits 0..2: start-up, high gain, orientation-only.
// - software bit3 set while yaw rate exceeds the turning threshold.
// - sensing alert flag is OR of sensing word AND mask; bit0 range.
// - masks use parameter identifiers 0x0010 to 0x0013 in group order.
// - any written mask value is accepted and kept.
// - enabled asserted bit raises group and top flags; cleared mask blocks.
// - top alert flag is OR of the four group flags.
// - summary bit8 top, bits 9..12 hardware, link, software, sensing.
// - summary bit3 is OR of algorithm and data fault summaries.
`timescale 1ns/1ns
module haa_aggregator
    import haa_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst_b,
    input  wire haa_cond_s      cond,
    input  wire logic [15:0]    yaw_rate,
    input  wire logic [15:0]    turn_thresh,
    input  wire haa_param_req_s param_req,
    output haa_param_rsp_s      param_rsp,
    output haa_status_s         status
);

    // maps a parameter identifier to an alert group
    function automatic logic [2:0] id_to_grp(input logic [15:0] id);
        logic [2:0] r;
        r = 3'h0;
        if (id == HAA_ID_HW_MASK) begin
            r = {1'b1, HAA_GRP_HW};
        end else if (id == HAA_ID_LINK_MASK) begin
            r = {1'b1, HAA_GRP_LINK};
        end else if (id == HAA_ID_SW_MASK) begin
            r = {1'b1, HAA_GRP_SW};
        end else if (id == HAA_ID_SENSING_MASK) begin
            r = {1'b1, HAA_GRP_SENSING};
        end
        return r;
    endfunction : id_to_grp

    // masked reduction of one alert group
    function automatic logic masked_any(input logic [15:0] word,
                                        input logic [15:0] mask,
                                        input logic [15:0] impl);
        return |(word & mask & impl);
    endfunction : masked_any

    logic [15:0] algo_fault_ff;
    logic [15:0] data_fault_ff;
    logic [15:0] nxt_algo_fault;
    logic [15:0] nxt_data_fault;
    logic        algo_sum_ff;
    logic        data_sum_ff;
    logic        sw_fault_ff;
    logic        top_flag_ff;
    logic [15:0] alert_word_ff [HAA_NGRP];
    logic [15:0] mask_ff       [HAA_NGRP];
    logic [15:0] nxt_alert     [HAA_NGRP];
    logic [15:0] impl_bits     [HAA_NGRP];
    logic        grp_flag_ff   [HAA_NGRP];
    logic        nxt_grp_flag  [HAA_NGRP];
    logic        rsp_ack_ff;
    logic        rsp_err_ff;
    logic [15:0] rsp_rdata_ff;

    // ---------------- software fault words ----------------
    wire [15:0] algo_set;
    wire [15:0] data_set;
    wire        turning;

    assign algo_set = (16'(cond.algo_start_err)    << HAA_ALGO_START_BIT)
                    | (16'(cond.range_fatal)       << HAA_ALGO_RANGE_BIT)
                    | (16'(cond.nav_deadline_miss) << HAA_ALGO_NAV_BIT);

    assign data_set = 16'(cond.cal_checksum_bad | cond.cal_compromised)
                      << HAA_DATA_CAL_BIT;

    // hard faults are sticky until reset; reserved bits stripped
    assign nxt_algo_fault = (algo_fault_ff | algo_set) & HAA_ALGO_IMPL;
    assign nxt_data_fault = (data_fault_ff | data_set) & HAA_DATA_IMPL;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            algo_fault_ff <= HAA_WORD_RST;
            data_fault_ff <= HAA_WORD_RST;
        end else begin
            algo_fault_ff <= nxt_algo_fault;
            data_fault_ff <= nxt_data_fault;
        end
    end

    wire nxt_algo_sum;
    wire nxt_data_sum;

    assign nxt_algo_sum = |(algo_fault_ff & HAA_ALGO_IMPL);
    assign nxt_data_sum = |(data_fault_ff & HAA_DATA_IMPL);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            algo_sum_ff <= 1'b0;
            data_sum_ff <= 1'b0;
            sw_fault_ff <= 1'b0;
        end else begin
            algo_sum_ff <= nxt_algo_sum;
            data_sum_ff <= nxt_data_sum;
            sw_fault_ff <= nxt_algo_sum | nxt_data_sum;
        end
    end

    // ---------------- alert words ----------------
    assign turning = yaw_rate > turn_thresh;

    assign nxt_alert[HAA_GRP_HW] =
          ((16'(cond.pps_unlock)          << HAA_HW_PPS_BIT)
         | (16'(cond.onboard_gnss_unlock) << HAA_HW_GNSS_BIT)
         | (16'(cond.no_diff_correction)  << HAA_HW_DIFF_BIT)
         | (16'(cond.cal_store_writable)  << HAA_HW_STORE_BIT))
         & HAA_HW_IMPL;

    assign nxt_alert[HAA_GRP_LINK] =
          (16'(cond.ext_gnss_absent) << HAA_LINK_EXT_BIT)
         & HAA_LINK_IMPL;

    assign nxt_alert[HAA_GRP_SW] =
          ((16'(cond.algo_starting)         << HAA_SW_START_BIT)
         | (16'(cond.strong_gain_mode)      << HAA_SW_GAIN_BIT)
         | (16'(cond.orientation_only_mode) << HAA_SW_ORIENT_BIT)
         | (16'(turning)                    << HAA_SW_TURN_BIT))
         & HAA_SW_IMPL;

    assign nxt_alert[HAA_GRP_SENSING] =
          (16'(cond.range_exceeded) << HAA_SENS_RANGE_BIT)
         & HAA_SENSING_IMPL;

    assign impl_bits[HAA_GRP_HW]      = HAA_HW_IMPL;
    assign impl_bits[HAA_GRP_LINK]    = HAA_LINK_IMPL;
    assign impl_bits[HAA_GRP_SW]      = HAA_SW_IMPL;
    assign impl_bits[HAA_GRP_SENSING] = HAA_SENSING_IMPL;

    // ---------------- parameter port decode ----------------
    wire [2:0] wr_grp;
    wire [2:0] rd_grp;
    wire       wr_hit;
    wire       rd_hit;

    assign wr_grp = id_to_grp(param_req.id);
    assign rd_grp = wr_grp;
    assign wr_hit = param_req.wr & wr_grp[2];
    assign rd_hit = param_req.rd & rd_grp[2];

    // ---------------- per-group mask, word and flag ----------------
    for (genvar g = 0; g < HAA_NGRP; g++) begin : g_grp
        wire       wr_this;
        wire [15:0] nxt_mask;

        assign wr_this  = wr_hit & (wr_grp[1:0] == 2'(g));
        assign nxt_mask = wr_this ? param_req.wdata : mask_ff[g];

        // group flag from the current registered word and mask
        assign nxt_grp_flag[g] = masked_any(alert_word_ff[g], mask_ff[g],
                                            impl_bits[g]);

        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                mask_ff[g]       <= HAA_MASK_RST;
                alert_word_ff[g] <= HAA_WORD_RST;
                grp_flag_ff[g]   <= 1'b0;
            end else begin
                mask_ff[g]       <= nxt_mask;
                alert_word_ff[g] <= nxt_alert[g];
                grp_flag_ff[g]   <= nxt_grp_flag[g];
            end
        end
    end

    // group flags, spelled out per group
    wire hw_any;
    wire link_any;
    wire sw_any;
    wire sens_any;
    wire nxt_top_flag;

    assign hw_any   = nxt_grp_flag[HAA_GRP_HW];
    assign link_any = nxt_grp_flag[HAA_GRP_LINK];
    assign sw_any   = nxt_grp_flag[HAA_GRP_SW];
    assign sens_any = nxt_grp_flag[HAA_GRP_SENSING];
    assign nxt_top_flag = hw_any | link_any | sw_any | sens_any;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            top_flag_ff <= 1'b0;
        end else begin
            top_flag_ff <= nxt_top_flag;
        end
    end

    // ---------------- parameter response ----------------
    wire        nxt_ack;
    wire        nxt_err;
    wire [15:0] nxt_rdata;

    assign nxt_ack   = param_req.wr | param_req.rd;
    assign nxt_err   = (param_req.wr & ~wr_grp[2]) | (param_req.rd & ~rd_grp[2]);
    assign nxt_rdata = rd_hit ? mask_ff[rd_grp[1:0]] : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rsp_ack_ff   <= 1'b0;
            rsp_err_ff   <= 1'b0;
            rsp_rdata_ff <= 16'h0000;
        end else begin
            rsp_ack_ff   <= nxt_ack;
            rsp_err_ff   <= nxt_err;
            rsp_rdata_ff <= nxt_rdata;
        end
    end

    assign param_rsp.ack   = rsp_ack_ff;
    assign param_rsp.err   = rsp_err_ff;
    assign param_rsp.rdata = rsp_rdata_ff;

    // ---------------- status outputs ----------------
    wire [15:0] summary;
    wire [15:0] swg;

    assign summary = (16'(sw_fault_ff)                   << HAA_SUM_SW_FAULT_BIT)
                   | (16'(top_flag_ff)                   << HAA_SUM_TOP_BIT)
                   | (16'(grp_flag_ff[HAA_GRP_HW])       << HAA_SUM_GRP_BASE)
                   | (16'(grp_flag_ff[HAA_GRP_LINK])     << (HAA_SUM_GRP_BASE + 1))
                   | (16'(grp_flag_ff[HAA_GRP_SW])       << (HAA_SUM_GRP_BASE + 2))
                   | (16'(grp_flag_ff[HAA_GRP_SENSING])  << (HAA_SUM_GRP_BASE + 3));

    assign swg = (16'(algo_sum_ff) << HAA_SWG_ALGO_BIT)
               | (16'(data_sum_ff) << HAA_SWG_DATA_BIT);

    assign status.health_summary_word = summary;
    assign status.sw_fault_group      = swg;
    assign status.algo_fault_word     = algo_fault_ff;
    assign status.data_fault_word     = data_fault_ff;
    assign status.hw_alert_word       = alert_word_ff[HAA_GRP_HW];
    assign status.link_alert_word     = alert_word_ff[HAA_GRP_LINK];
    assign status.sw_alert_word       = alert_word_ff[HAA_GRP_SW];
    assign status.sensing_alert_word  = alert_word_ff[HAA_GRP_SENSING];

endmodule : haa_aggregator

// [include/haa_pkg.sv]
// Purpose: shared constants and carriers for the health alert aggregator
// Assumes: 16-bit parameter words, field identifiers as parameter numbers
// Notes:   group index order is hardware, link, software, sensing
package haa_pkg;

    // parameter identifiers of the four alert masks
    localparam logic [15:0] HAA_ID_HW_MASK      = 16'h0010;
    localparam logic [15:0] HAA_ID_LINK_MASK    = 16'h0011;
    localparam logic [15:0] HAA_ID_SW_MASK      = 16'h0012;
    localparam logic [15:0] HAA_ID_SENSING_MASK = 16'h0013;

    localparam int HAA_NGRP = 4;
    localparam logic [1:0] HAA_GRP_HW      = 2'h0;
    localparam logic [1:0] HAA_GRP_LINK    = 2'h1;
    localparam logic [1:0] HAA_GRP_SW      = 2'h2;
    localparam logic [1:0] HAA_GRP_SENSING = 2'h3;

    // algorithm fault word
    localparam int HAA_ALGO_START_BIT = 0;
    localparam int HAA_ALGO_RANGE_BIT = 1;
    localparam int HAA_ALGO_NAV_BIT   = 2;
    // data fault word
    localparam int HAA_DATA_CAL_BIT   = 0;
    // hardware alert word
    localparam int HAA_HW_PPS_BIT     = 0;
    localparam int HAA_HW_GNSS_BIT    = 1;
    localparam int HAA_HW_DIFF_BIT    = 2;
    localparam int HAA_HW_STORE_BIT   = 3;
    // link alert word
    localparam int HAA_LINK_EXT_BIT   = 0;
    // software alert word
    localparam int HAA_SW_START_BIT   = 0;
    localparam int HAA_SW_GAIN_BIT    = 1;
    localparam int HAA_SW_ORIENT_BIT  = 2;
    localparam int HAA_SW_TURN_BIT    = 3;
    // sensing alert word
    localparam int HAA_SENS_RANGE_BIT = 0;
    // software fault group
    localparam int HAA_SWG_ALGO_BIT   = 0;
    localparam int HAA_SWG_DATA_BIT   = 1;
    // health summary word
    localparam int HAA_SUM_SW_FAULT_BIT = 3;
    localparam int HAA_SUM_TOP_BIT      = 8;
    localparam int HAA_SUM_GRP_BASE     = 9;

    // implemented bits; everything else is reserved and held at zero
    localparam logic [15:0] HAA_ALGO_IMPL    = 16'h0007;
    localparam logic [15:0] HAA_DATA_IMPL    = 16'h0001;
    localparam logic [15:0] HAA_HW_IMPL      = 16'h000F;
    localparam logic [15:0] HAA_LINK_IMPL    = 16'h0001;
    localparam logic [15:0] HAA_SW_IMPL      = 16'h000F;
    localparam logic [15:0] HAA_SENSING_IMPL = 16'h0001;

    localparam logic [15:0] HAA_MASK_RST = 16'h0000;
    localparam logic [15:0] HAA_WORD_RST = 16'h0000;

    typedef struct packed {
        logic algo_start_err;
        logic range_fatal;
        logic nav_deadline_miss;
        logic cal_checksum_bad;
        logic cal_compromised;
        logic pps_unlock;
        logic onboard_gnss_unlock;
        logic no_diff_correction;
        logic cal_store_writable;
        logic ext_gnss_absent;
        logic algo_starting;
        logic strong_gain_mode;
        logic orientation_only_mode;
        logic range_exceeded;
    } haa_cond_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] id;
        logic [15:0] wdata;
    } haa_param_req_s;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } haa_param_rsp_s;

    typedef struct packed {
        logic [15:0] health_summary_word;
        logic [15:0] sw_fault_group;
        logic [15:0] algo_fault_word;
        logic [15:0] data_fault_word;
        logic [15:0] hw_alert_word;
        logic [15:0] link_alert_word;
        logic [15:0] sw_alert_word;
        logic [15:0] sensing_alert_word;
    } haa_status_s;

endpackage : haa_pkg

// [tb/haa_aggregator_properties.sv]
// Purpose: port checker for the health alert aggregator
// Assumes: one clock, masks tracked from parameter writes
// Notes:   bound to every haa_aggregator instance
`timescale 1ns/1ns
module haa_chk
    import haa_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           rst_b,
    input wire haa_cond_s      cond,
    input wire logic [15:0]    yaw_rate,
    input wire logic [15:0]    turn_thresh,
    input wire haa_param_req_s param_req,
    input wire haa_param_rsp_s param_rsp,
    input wire haa_status_s    status
);
    logic [15:0] mask_ff [4];
    wire         id_ok = param_req.id >= HAA_ID_HW_MASK && param_req.id <= HAA_ID_SENSING_MASK;
    wire [15:0]  mask_sel = mask_ff[param_req.id[1:0]];
    wire [15:0]  hsw = status.health_summary_word;
    wire [3:0]   grp_hit = {|(status.sensing_alert_word & mask_ff[3]),
                            |(status.sw_alert_word & mask_ff[2]),
                            |(status.link_alert_word & mask_ff[1]),
                            |(status.hw_alert_word & mask_ff[0])};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) mask_ff <= '{default: HAA_MASK_RST};
        else if (param_req.wr && id_ok) mask_ff[param_req.id[1:0]] <= param_req.wdata;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_req_taken;
        $past(rst_b) && (param_req.wr || param_req.rd);
    endsequence
    property p_ack;
        s_req_taken |=> param_rsp.ack;
    endproperty
    property p_no_ack;
        $past(rst_b) && !(param_req.wr || param_req.rd) |=> !param_rsp.ack;
    endproperty
    property p_err;
        $past(rst_b) && param_rsp.ack |-> param_rsp.err == !$past(id_ok);
    endproperty
    property p_rdata;
        $past(rst_b) && param_rsp.ack && $past(param_req.rd)
            |-> param_rsp.rdata == ($past(id_ok) ? $past(mask_sel) : 16'h0000);
    endproperty
    property p_hw_link;
        $past(rst_b) |-> status.hw_alert_word == {12'h000, $past({cond.cal_store_writable,
            cond.no_diff_correction, cond.onboard_gnss_unlock, cond.pps_unlock})}
            && status.link_alert_word == {15'h0000, $past(cond.ext_gnss_absent)};
    endproperty
    property p_sw_sens;
        $past(rst_b) |-> status.sw_alert_word == {12'h000, $past({yaw_rate > turn_thresh,
            cond.orientation_only_mode, cond.strong_gain_mode, cond.algo_starting})}
            && status.sensing_alert_word == {15'h0000, $past(cond.range_exceeded)};
    endproperty
    property p_faults;
        $past(rst_b) |-> status.algo_fault_word == ($past(status.algo_fault_word)
            | {13'h0000, $past({cond.nav_deadline_miss, cond.range_fatal, cond.algo_start_err})})
            && status.data_fault_word == ($past(status.data_fault_word)
            | {15'h0000, $past(cond.cal_checksum_bad || cond.cal_compromised)});
    endproperty
    property p_fault_sum;
        $past(rst_b) |-> status.sw_fault_group
            == {14'h0000, $past(|status.data_fault_word), $past(|status.algo_fault_word)};
    endproperty
    property p_groups;
        $past(rst_b) |-> hsw[12:9] == $past(grp_hit);
    endproperty
    property p_top;
        hsw[8] == |hsw[12:9] && hsw[3] == |status.sw_fault_group[1:0];
    endproperty
    property p_reserved;
        (hsw & 16'hE0F7) == 16'h0000 && (status.sw_fault_group & 16'hFFFC) == 16'h0000;
    endproperty

    a_ack: assert property (p_ack) else $error("no ack after request");
    a_no_ack: assert property (p_no_ack) else $error("ack without request");
    a_err: assert property (p_err) else $error("wrong err on ack");
    a_rdata: assert property (p_rdata) else $error("wrong mask read back");
    a_hw_link: assert property (p_hw_link) else $error("hw or link word wrong");
    a_sw_sens: assert property (p_sw_sens)
        else $error("sw or sensing word wrong");
    a_faults: assert property (p_faults) else $error("fault word wrong");
    a_fault_sum: assert property (p_fault_sum) else $error("fault summary wrong");
    a_groups: assert property (p_groups)
        else $error("group flags wrong");
    a_top: assert property (p_top) else $error("top or sw fault flag wrong");
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
endmodule : haa_chk

bind haa_aggregator haa_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .cond(cond),
    .yaw_rate(yaw_rate), .turn_thresh(turn_thresh), .param_req(param_req),
    .param_rsp(param_rsp), .status(status));

// [tb/tb_top.sv]
// Purpose: directed bench for the health alert aggregator
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   fault words are sticky, so each fault case starts from reset
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("MISMATCH %s exp=%h got=%h", nm, e, g); \
    end \
end
module tb_top;
    import haa_pkg::*;
    logic           clk_sys;
    logic           rst_b;
    haa_cond_s      cond;
    logic [15:0]    yaw_rate;
    logic [15:0]    turn_thresh;
    haa_param_req_s param_req;
    haa_param_rsp_s param_rsp;
    haa_status_s    status;
    wire [15:0]     hsw_seen = status.health_summary_word;
    int             bad_count;
    int             total_checks;
    int             cycles;

    haa_aggregator dut (.clk_sys(clk_sys), .rst_b(rst_b), .cond(cond), .yaw_rate(yaw_rate),
        .turn_thresh(turn_thresh), .param_req(param_req), .param_rsp(param_rsp),
        .status(status));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic do_reset;
        rst_b = 1'b0;
        cond = '0;
        step(10);
        rst_b = 1'b1;
    endtask : do_reset

    task automatic prm(input logic w, input logic r, input logic [15:0] id,
                       input logic [15:0] wd, output haa_param_rsp_s rsp);
        param_req = '{wr: w, rd: r, id: id, wdata: wd};
        step(1);
        rsp = param_rsp;
        param_req = '0;
        // one idle edge so the next call never re-drives in this step
        step(1);
    endtask : prm

    function automatic logic [15:0] word_of(input int g);
        case (g)
            0: return status.hw_alert_word;
            1: return status.link_alert_word;
            2: return status.sw_alert_word;
            default: return status.sensing_alert_word;
        endcase
    endfunction : word_of

    task automatic t_regs;
        haa_param_rsp_s r;
        for (int g = 0; g < 4; g++) begin
            prm(1'b0, 1'b1, 16'(HAA_ID_HW_MASK + g), 16'h0000, r);
            `CHK("mask_rst", 16'h0000, r.rdata)
            prm(1'b1, 1'b0, 16'(HAA_ID_HW_MASK + g), 16'(16'hFFFF - g * 16'h1111), r);
            `CHK("wr_err", 2'b10, {r.ack, r.err})
        end
        for (int g = 0; g < 4; g++) begin
            prm(1'b0, 1'b1, 16'(HAA_ID_HW_MASK + g), 16'h0000, r);
            `CHK("mask_rd", 16'(16'hFFFF - g * 16'h1111), r.rdata)
        end
        prm(1'b1, 1'b1, 16'h0014, 16'h1234, r);
        `CHK("bad_id", 18'h20000 | 18'h10000, {r.ack, r.err, r.rdata})
        prm(1'b0, 1'b1, 16'h000F, 16'h0000, r);
        `CHK("bad_id_rd", 2'b11, {r.ack, r.err})
        prm(1'b1, 1'b1, HAA_ID_SW_MASK, 16'h0008, r);
        `CHK("wr_rd_old", 16'hDDDD, r.rdata)
        prm(1'b0, 1'b1, HAA_ID_SW_MASK, 16'h0000, r);
        `CHK("wr_rd_new", 16'h0008, r.rdata)
    endtask : t_regs

    task automatic t_alerts;
        haa_param_rsp_s r;
        int grp [10] = '{0, 0, 0, 0, 1, 2, 2, 2, 3, 2};
        int bn [10] = '{0, 1, 2, 3, 0, 0, 1, 2, 0, 3};
        logic [15:0] seen;
        for (int g = 0; g < 4; g++) prm(1'b1, 1'b0, 16'(HAA_ID_HW_MASK + g), 16'hFFFF, r);
        for (int i = 0; i < 10; i++) begin
            cond = (i < 9) ? haa_cond_s'(14'h0100 >> i) : '0;
            yaw_rate = (i == 9) ? 16'h0065 : 16'h0064;
            step(2);
            seen = word_of(grp[i]);
            `CHK("alert_word", 16'(1 << bn[i]), seen)
            `CHK("summary", 16'(16'h0100 | (16'h0200 << grp[i])), hsw_seen)
            prm(1'b1, 1'b0, 16'(HAA_ID_HW_MASK + grp[i]), 16'(~(1 << bn[i])), r);
            step(1);
            `CHK("blocked", 16'h0000, status.health_summary_word)
            prm(1'b1, 1'b0, 16'(HAA_ID_HW_MASK + grp[i]), 16'hFFFF, r);
        end
        yaw_rate = 16'h0064;
    endtask : t_alerts

    task automatic t_faults;
        for (int i = 0; i < 5; i++) begin
            do_reset();
            cond = haa_cond_s'(14'h2000 >> i);
            step(1);
            cond = '0;
            step(3);
            `CHK("algo_word", (i < 3) ? 16'(1 << i) : 16'h0000, status.algo_fault_word)
            `CHK("data_word", 16'(i > 2), status.data_fault_word)
            `CHK("fault_grp", (i < 3) ? 16'h0001 : 16'h0002, status.sw_fault_group)
            `CHK("sw_fault", 16'h0008, status.health_summary_word)
        end
    endtask : t_faults

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        yaw_rate = 16'h0064;
        turn_thresh = 16'h0064;
        param_req = '0;
        do_reset();
        t_regs();
        t_alerts();
        t_faults();
        close_out();
    end
endmodule : tb_top
